// ### verilog/cio_pkg.sv
/*
 * Package for the CAN interrupt-enable and receive-overflow register block.
 * It holds the register offsets, field positions, masks and AXI4-Lite responses.
 * It assumes a 32-bit AXI4-Lite bus and a 12-bit byte address.
 */
`default_nettype none

package cio_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_BUF = 16;
    localparam int NUM_SRC = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_RX_OVF_LOW = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_IRQ_PENDING = 12'h008;

    // enable bit positions
    localparam int BIT_TX_BUFFER = 0;
    localparam int BIT_RX_BUFFER = 1;
    localparam int BIT_RX_OVERFLOW = 2;
    localparam int BIT_FIFO_ALMOST_FULL = 3;
    localparam int BIT_ERROR = 5;
    localparam int BIT_BUS_WAKEUP = 6;
    localparam int BIT_INVALID_MSG = 7;

    // implemented enable bits: 7..5 and 3..0
    localparam logic [NUM_SRC-1:0] IRQ_ENABLE_MASK = 8'hef;
    localparam logic [NUM_SRC-1:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [NUM_BUF-1:0] RX_OVF_RESET = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// ### verilog/cio_sticky_flag.sv
/*
 * One sticky flag: set by hardware, cleared by software, set wins.
 * Assumes set and clear are single-cycle requests on the same clock.
 */
`default_nettype none

module cio_sticky_flag (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic set,
    input wire logic clr,
    output logic flag
);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### verilog/cio_regs.sv
/*
 * CAN interrupt-enable register and receive buffer overflow register (buffers 0..15),
 * reached over AXI4-Lite, with a gated interrupt request output.
 * Assumes event flags are levels from the interrupt flag logic and that
 * wr_to_full pulses when a received message is directed to a full buffer.
 */
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`default_nettype none

// How it works
// - enable bits 7,6,5,3,2,1,0 for seven event sources, individually writable.
// - an enable bit at one lets its source raise an interrupt request.
// - an enable bit at zero blocks its source; all enables zero after reset.
// - one overflow flag per buffer 0..15, set on a write to a full buffer.
// - overflow flags stay set until software clears; software cannot set; reset zero.

module cio_regs #(
    parameter int ADDR_W = cio_pkg::ADDR_W,
    parameter int NUM_BUF = cio_pkg::NUM_BUF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [cio_pkg::NUM_SRC-1:0] event_flags,
    input wire logic [NUM_BUF-1:0] wr_to_full,
    output logic [cio_pkg::NUM_SRC-1:0] irq_req,
    output logic irq,
    output logic [NUM_BUF-1:0] rx_buffer_overflow_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // write channel capture

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_hs;
    logic w_hs;
    logic do_write;
    logic next_aw_held;
    logic next_w_held;

    assign aw_hs = awvalid & awready;
    assign w_hs = wvalid & wready;
    assign do_write = aw_held & w_held & ~bvalid;
    assign next_aw_held = aw_hs | (aw_held & ~do_write);
    assign next_w_held = w_hs | (w_held & ~do_write);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awready <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            awready <= ~next_aw_held;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wready <= 1'b0;
        end else begin
            w_held <= next_w_held;
            wready <= ~next_w_held;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= '0;
        end else if (aw_hs) begin
            aw_addr_q <= awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (w_hs) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write decode

    logic wr_sel_en;
    logic wr_sel_ovf;
    logic wr_sel_pend;
    logic wr_mapped;

    assign wr_sel_en = aw_addr_q[ADDR_W-1:2] == cio_pkg::OFS_IRQ_ENABLE[ADDR_W-1:2];
    assign wr_sel_ovf = aw_addr_q[ADDR_W-1:2] == cio_pkg::OFS_RX_OVF_LOW[ADDR_W-1:2];
    assign wr_sel_pend = aw_addr_q[ADDR_W-1:2] == cio_pkg::OFS_IRQ_PENDING[ADDR_W-1:2];
    assign wr_mapped = wr_sel_en | wr_sel_ovf | wr_sel_pend;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= cio_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_mapped ? cio_pkg::RESP_OKAY : cio_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt enable register, one field per event source

    localparam logic [cio_pkg::NUM_SRC-1:0] EN_RST = cio_pkg::IRQ_ENABLE_RESET;

    logic en_wr;
    logic tx_buffer_irq_en;
    logic rx_buffer_irq_en;
    logic rx_overflow_irq_en;
    logic fifo_almost_full_irq_en;
    logic error_irq_en;
    logic bus_wakeup_irq_en;
    logic invalid_message_irq_en;
    logic [cio_pkg::NUM_SRC-1:0] can_interrupt_enable;

    assign en_wr = do_write & wr_sel_en & w_strb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buffer_irq_en <= EN_RST[cio_pkg::BIT_TX_BUFFER];
        end else if (en_wr) begin
            tx_buffer_irq_en <= w_data_q[cio_pkg::BIT_TX_BUFFER];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buffer_irq_en <= EN_RST[cio_pkg::BIT_RX_BUFFER];
        end else if (en_wr) begin
            rx_buffer_irq_en <= w_data_q[cio_pkg::BIT_RX_BUFFER];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_overflow_irq_en <= EN_RST[cio_pkg::BIT_RX_OVERFLOW];
        end else if (en_wr) begin
            rx_overflow_irq_en <= w_data_q[cio_pkg::BIT_RX_OVERFLOW];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_almost_full_irq_en <= EN_RST[cio_pkg::BIT_FIFO_ALMOST_FULL];
        end else if (en_wr) begin
            fifo_almost_full_irq_en <= w_data_q[cio_pkg::BIT_FIFO_ALMOST_FULL];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_irq_en <= EN_RST[cio_pkg::BIT_ERROR];
        end else if (en_wr) begin
            error_irq_en <= w_data_q[cio_pkg::BIT_ERROR];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_wakeup_irq_en <= EN_RST[cio_pkg::BIT_BUS_WAKEUP];
        end else if (en_wr) begin
            bus_wakeup_irq_en <= w_data_q[cio_pkg::BIT_BUS_WAKEUP];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            invalid_message_irq_en <= EN_RST[cio_pkg::BIT_INVALID_MSG];
        end else if (en_wr) begin
            invalid_message_irq_en <= w_data_q[cio_pkg::BIT_INVALID_MSG];
        end
    end

    // unimplemented positions stay zero
    always_comb begin
        can_interrupt_enable = '0;
        can_interrupt_enable[cio_pkg::BIT_TX_BUFFER] = tx_buffer_irq_en;
        can_interrupt_enable[cio_pkg::BIT_RX_BUFFER] = rx_buffer_irq_en;
        can_interrupt_enable[cio_pkg::BIT_RX_OVERFLOW] = rx_overflow_irq_en;
        can_interrupt_enable[cio_pkg::BIT_FIFO_ALMOST_FULL] = fifo_almost_full_irq_en;
        can_interrupt_enable[cio_pkg::BIT_ERROR] = error_irq_en;
        can_interrupt_enable[cio_pkg::BIT_BUS_WAKEUP] = bus_wakeup_irq_en;
        can_interrupt_enable[cio_pkg::BIT_INVALID_MSG] = invalid_message_irq_en;
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive buffer overflow flags

    logic [NUM_BUF-1:0] ovf_clr;

    always_comb begin
        ovf_clr = '0;
        for (int i = 0; i < NUM_BUF; i++) begin
            // writing zero clears, writing one leaves the flag alone
            ovf_clr[i] = do_write & wr_sel_ovf & w_strb_q[i/8] & ~w_data_q[i];
        end
    end

    generate
        for (genvar g = 0; g < NUM_BUF; g++) begin : g_ovf
            cio_sticky_flag u_flag (
                .aclk(aclk),
                .aresetn(aresetn),
                .set(wr_to_full[g]),
                .clr(ovf_clr[g]),
                .flag(rx_buffer_overflow_flag[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // interrupt gating

    logic [cio_pkg::NUM_SRC-1:0] next_irq_req;

    assign next_irq_req = event_flags & can_interrupt_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req <= '0;
            irq <= 1'b0;
        end else begin
            irq_req <= next_irq_req;
            irq <= |next_irq_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read channel

    logic ar_hs;
    logic rd_sel_en;
    logic rd_sel_ovf;
    logic rd_sel_pend;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    assign ar_hs = arvalid & arready;
    assign rd_sel_en = araddr[ADDR_W-1:2] == cio_pkg::OFS_IRQ_ENABLE[ADDR_W-1:2];
    assign rd_sel_ovf = araddr[ADDR_W-1:2] == cio_pkg::OFS_RX_OVF_LOW[ADDR_W-1:2];
    assign rd_sel_pend = araddr[ADDR_W-1:2] == cio_pkg::OFS_IRQ_PENDING[ADDR_W-1:2];

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = cio_pkg::RESP_OKAY;
        if (rd_sel_en) begin
            next_rdata[7:0] = can_interrupt_enable;
        end else if (rd_sel_ovf) begin
            next_rdata[NUM_BUF-1:0] = rx_buffer_overflow_flag;
        end else if (rd_sel_pend) begin
            next_rdata[7:0] = irq_req;
        end else begin
            next_rresp = cio_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else begin
            arready <= ~ar_hs & (~rvalid | rready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= cio_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### sim/cio_regs_sva.sv
/*
 checker for the interrupt-enable and overflow register block.
 assumes it is bound to cio_regs and sees its ports only.
 */
`default_nettype none

module cio_regs_sva #(
    parameter int NUM_BUF = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [cio_pkg::NUM_SRC-1:0] event_flags,
    input wire logic [cio_pkg::NUM_SRC-1:0] irq_req,
    input wire logic irq,
    input wire logic [NUM_BUF-1:0] wr_to_full,
    input wire logic [NUM_BUF-1:0] rx_buffer_overflow_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////
    sequence s_wr_take;
        awvalid && awready && wvalid && wready && !bvalid;
    endsequence
    sequence s_wr_done;
        !awready && !wready ##1 bvalid && awready && wready;
    endsequence
    property p_wr_resp;
        s_wr_take |=> s_wr_done;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    property p_wr_end;
        bvalid && bready |=> !bvalid;
    endproperty
    a_wr_end: assert property (p_wr_end) else $error("bvalid stuck");
    property p_rd_resp;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    property p_rd_end;
        rvalid && rready |=> !rvalid && arready;
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("rvalid stuck");

    ////////////////////////////////////////////////////////////////
    property p_irq_gate;
        (irq_req & ~$past(event_flags)) == '0 && !irq_req[4];
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without event");
    property p_irq_or;
        irq == |irq_req;
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq not or of requests");
    property p_ovf_set;
        |wr_to_full |=> (rx_buffer_overflow_flag & $past(wr_to_full)) == $past(wr_to_full);
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");
    property p_ovf_rise;
        (rx_buffer_overflow_flag & ~$past(rx_buffer_overflow_flag) & ~$past(wr_to_full)) == '0;
    endproperty
    a_ovf_rise: assert property (p_ovf_rise) else $error("overflow set alone");
    property p_ovf_fall;
        $past(aresetn) && |($past(rx_buffer_overflow_flag) & ~rx_buffer_overflow_flag)
            |-> $rose(bvalid);
    endproperty
    a_ovf_fall: assert property (p_ovf_fall) else $error("overflow lost");
endmodule

bind cio_regs cio_regs_sva #(.NUM_BUF(NUM_BUF)) u_sva (.aclk, .aresetn, .awvalid, .awready,
    .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .event_flags,
    .irq_req, .irq, .wr_to_full, .rx_buffer_overflow_flag);

`default_nettype wire

// ### sim/tb.sv
/*
 self-checking bench for cio_regs over AXI4-Lite.
 assumes cio_pkg and the bound checker are compiled first.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_EN = cio_pkg::OFS_IRQ_ENABLE;
    localparam logic [11:0] A_OVF = cio_pkg::OFS_RX_OVF_LOW;
    localparam logic [11:0] A_PEND = cio_pkg::OFS_IRQ_PENDING;
    // enable write, event flags, enable read back
    localparam logic [31:0] ROWS [5][3] = '{'{32'hffffffff, 32'hff, 32'hef},
        '{32'h0, 32'hff, 32'h0}, '{32'h10, 32'hff, 32'h0}, '{32'h21, 32'h31, 32'h21},
        '{32'h8e, 32'h0, 32'h8e}};
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [7:0] event_flags, irq_req;
    logic [15:0] wr_to_full, ovf;
    int error_cnt, checks;

    cio_regs dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .event_flags, .wr_to_full, .irq_req, .irq,
        .rx_buffer_overflow_flag(ovf));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
        output logic [1:0] rs);
        logic aw_on;
        logic w_on;
        logic b_on;
        aw_on = 1'b1;
        w_on = 1'b1;
        b_on = 1'b1;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw_on || w_on || b_on) begin
            @(posedge aclk);
            if (aw_on && awready) begin
                aw_on = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_on && wready) begin
                w_on = 1'b0;
                wvalid <= 1'b0;
            end
            if (b_on && bvalid) begin
                rs = bresp;
                b_on = 1'b0;
                bready <= 1'b0;
            end
        end
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ar_on;
        logic r_on;
        ar_on = 1'b1;
        r_on = 1'b1;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (ar_on || r_on) begin
            @(posedge aclk);
            if (ar_on && arready) begin
                ar_on = 1'b0;
                arvalid <= 1'b0;
            end
            if (r_on && rvalid) begin
                v = rdata;
                rs = rresp;
                r_on = 1'b0;
                rready <= 1'b0;
            end
        end
        @(posedge aclk);
    endtask

    task automatic rst;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge aclk);
        error_cnt++;
        results;
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, event_flags, wr_to_full} = '0;
        error_cnt = 0;
        checks = 0;
        rst;
        rd(A_EN, d, r);
        chk("enable", 32'h0, d);
        rd(A_OVF, d, r);
        chk("overflow", 32'h0, d);
        foreach (ROWS[i]) begin
            wr(A_EN, ROWS[i][0], 4'hf, r);
            event_flags <= ROWS[i][1][7:0];
            repeat (2) @(posedge aclk);
            chk("irq_req", ROWS[i][2] & ROWS[i][1], {24'h0, irq_req});
            chk("irq", {31'h0, |(ROWS[i][2] & ROWS[i][1])}, {31'h0, irq});
            rd(A_PEND, d, r);
            chk("pending", ROWS[i][2] & ROWS[i][1], d);
            rd(A_EN, d, r);
            chk("enable", ROWS[i][2], d);
        end
        wr_to_full <= 16'h8001;
        @(posedge aclk);
        wr_to_full <= '0;
        rd(A_OVF, d, r);
        chk("overflow", 32'h8001, d);
        wr(A_OVF, 32'hffff, 4'hf, r);
        rd(A_OVF, d, r);
        chk("overflow", 32'h8001, d);
        wr(A_OVF, 32'hfe, 4'h1, r);
        chk("overflow_pin", 32'h8000, {16'h0, ovf});
        wr_to_full <= 16'h0002;
        wr(A_OVF, 32'h0, 4'h3, r);
        wr_to_full <= '0;
        chk("set_wins", 32'h2, {16'h0, ovf});
        wr(12'h00c, 32'hffffffff, 4'hf, r);
        chk("bresp", 32'h2, {30'h0, r});
        rd(12'h00c, d, r);
        chk("rresp", 32'h2, {30'h0, r});
        rst;
        chk("overflow_pin", 32'h0, {16'h0, ovf});
        rd(A_EN, d, r);
        chk("enable", 32'h0, d);
        results;
    end
endmodule

`default_nettype wire
